// ---- verilog/nmd_regs.svh ----
// Purpose: Constants for the nibble core opcode and operand decoder
// Assumes: 40 MHz core clock, synchronous reset
// Notes: Field ranges are used as part-selects of the instruction word, except NMD_F_PAGE, which selects the page bits of the program counter
`ifndef NMD_REGS_SVH
`define NMD_REGS_SVH

// Peripheral addresses
`define NMD_PA_NRZ_LOW 7'h03
`define NMD_PA_NRZ_HIGH 7'h04
`define NMD_PA_TIMER_COUNT 7'h05
`define NMD_PA_TIMER_MODULO 7'h06
`define NMD_PA_TABLE_ADDRESS 7'h40

// Reset values
`define NMD_RST_BYTE 8'h00
`define NMD_RST_WORD 16'h0000
`define NMD_RST_PC 13'h0000

// Instruction fields
`define NMD_F_FORM 15
`define NMD_F_MAJOR 14:11
`define NMD_F_ADDR 10:0
`define NMD_F_PAGE 12:11
`define NMD_F_SUBOP 10:7
`define NMD_F_MROW 10:8
`define NMD_F_REGCOL 7:4
`define NMD_F_IMM 7:4
`define NMD_F_MCOL 3:0
`define NMD_F_PHIGH 6:4
`define NMD_F_PLOW 3:0
`define NMD_F_RFROW 6:4
`define NMD_F_RFCOL 3:0

// Stack sizes
`define NMD_ASR_AW 3
`define NMD_IST_AW 2
`define NMD_STATUS_W 8

`endif

// ---- verilog/nmd_pkg.sv ----
// Purpose: Types for the nibble core opcode and operand decoder
// Assumes: Included constants header
// Notes: Decoded operands travel as one packed struct
`include "nmd_regs.svh"

package nmd_pkg;

    // Major opcode values (bits 14 to 11)
    typedef enum logic [3:0] {
        NMD_ADD = 4'h0, NMD_SUB = 4'h1, NMD_ADDC = 4'h2, NMD_SUBC = 4'h3,
        NMD_AND = 4'h4, NMD_XOR = 4'h5, NMD_OR = 4'h6, NMD_MISC = 4'h7,
        NMD_LDST = 4'h8, NMD_SKEGE = 4'h9, NMD_MOVIND = 4'hA, NMD_SKNELT = 4'hB,
        NMD_BR0 = 4'hC, NMD_BR1 = 4'hD, NMD_BR2 = 4'hE, NMD_BR3 = 4'hF
    } nmd_major_t;

    // Sub-operations of the miscellaneous group
    typedef enum logic [3:0] {
        NMD_S_INC_TA = 4'h0, NMD_S_INC_IX = 4'h1, NMD_S_MOVT = 4'h2, NMD_S_BR_TA = 4'h3,
        NMD_S_CALL_TA = 4'h4, NMD_S_RET = 4'h5, NMD_S_RETSK = 4'h6, NMD_S_EI = 4'h7,
        NMD_S_DI = 4'h8, NMD_S_RETI = 4'h9, NMD_S_PUSH = 4'hA, NMD_S_POP = 4'hB,
        NMD_S_GET = 4'hC, NMD_S_PUT = 4'hD, NMD_S_PEEK = 4'hE, NMD_S_POKE = 4'hF
    } nmd_subop_t;

    // Sequencer states
    typedef enum logic [1:0] {
        NMD_ST_RUN = 2'b01,
        NMD_ST_SKIP = 2'b10
    } nmd_state_t;

    typedef struct packed {
        logic [4:0] opcode;
        logic [6:0] mem_addr;
        logic [3:0] reg_col;
        logic [3:0] immediate_nibble;
        logic [3:0] bit_sel;
        logic [6:0] periph_addr;
        logic [6:0] regfile_addr;
        logic [10:0] branch_addr;
    } nmd_decode_t;

endpackage : nmd_pkg

// ---- verilog/nmd_stack_mem.sv ----
// Purpose: Small stack memory with registered read data
// Assumes: One write and one read port on one clock
// Notes: Write-first when both ports hit the same entry
`timescale 1ns/1ps

module nmd_stack_mem #(
    parameter int AW = 3,
    parameter int DW = 16
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        // Fresh push must be visible as the new top
        if (we && (waddr == raddr))
        begin
            rdata <= wdata;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end

endmodule : nmd_stack_mem

// ---- verilog/nmd_decode.sv ----
// Purpose: Opcode and operand decoder with program counter, stacks and peripheral registers
// Assumes: One instruction per INSTR_VALID pulse; all inputs except INT_PIN on CLOCK
// Notes: Results appear one cycle after the instruction is taken
`timescale 1ns/1ps

module nmd_decode
    import nmd_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // Instruction stream
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR,
    // Core context
    input wire logic [2:0] ROW_POINTER,
    input wire logic ROW_POINTER_EN,
    input wire logic [15:0] XFER_DATA,
    input wire logic [7:0] TIMER_COUNT,
    // Interrupt entry
    input wire logic INT_ACCEPT,
    input wire logic [12:0] INT_VECTOR,
    input wire logic [`NMD_STATUS_W-1:0] SAVED_STATUS,
    // External interrupt pin
    input wire logic INT_PIN,
    // Decode results
    output nmd_decode_t DECODE,
    output logic DECODE_VALID,
    // Program flow
    output logic [12:0] PC,
    output logic [15:0] PROG_ADDR,
    output logic PROG_READ,
    output logic [`NMD_ASR_AW-1:0] STACK_INDEX,
    output logic INT_ENABLE,
    output logic [`NMD_STATUS_W-1:0] RESTORED_STATUS,
    output logic RESTORE_VALID,
    // Peripheral registers
    output logic [15:0] PERIPH_RDATA,
    output logic PERIPH_RVALID,
    output logic [7:0] NRZ_LOW,
    output logic [7:0] NRZ_HIGH,
    output logic [7:0] TIMER_MODULO,
    output logic [15:0] TABLE_ADDR,
    // Register file flag
    output logic INT_LEVEL_FLAG
);

    function automatic nmd_decode_t split_word(input logic [15:0] w, input logic rp_en, input logic [2:0] rp);
        nmd_decode_t d;
        d.opcode = {w[`NMD_F_FORM], w[`NMD_F_MAJOR]};
        d.mem_addr = {(rp_en ? rp : w[`NMD_F_MROW]), w[`NMD_F_MCOL]};
        d.reg_col = w[`NMD_F_REGCOL];
        d.immediate_nibble = w[`NMD_F_IMM];
        d.bit_sel = w[`NMD_F_IMM];
        d.periph_addr = {w[`NMD_F_PHIGH], w[`NMD_F_PLOW]};
        d.regfile_addr = {w[`NMD_F_RFROW], w[`NMD_F_RFCOL]};
        d.branch_addr = w[`NMD_F_ADDR];
        return d;
    endfunction : split_word

    // Pin synchroniser
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic int_flag;
    logic next_int_flag;

    always_ff @(posedge CLOCK)
    begin
        pin_s1 <= INT_PIN;
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
    end

    always_comb
    begin
        next_int_flag = int_flag;
        if (RST || (pin_s2 == pin_s3))
        begin
            next_int_flag = pin_s3;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        int_flag <= next_int_flag;
    end

    // Decode and execution state
    nmd_decode_t dec;
    nmd_major_t major;
    nmd_subop_t subop;
    logic form;
    logic [12:0] pc_inc;

    nmd_state_t state, next_state;
    nmd_decode_t dec_q, next_dec_q;
    logic dec_valid, next_dec_valid;
    logic [12:0] pc, next_pc;
    logic [15:0] prog_addr, next_prog_addr;
    logic prog_read, next_prog_read;
    logic [`NMD_ASR_AW-1:0] sidx, next_sidx;
    logic [`NMD_IST_AW-1:0] iidx, next_iidx;
    logic int_en, next_int_en;
    logic [`NMD_STATUS_W-1:0] restored, next_restored;
    logic restore_valid, next_restore_valid;
    logic [15:0] prdata, next_prdata;
    logic prvalid, next_prvalid;
    logic [7:0] nrz_low, next_nrz_low;
    logic [7:0] nrz_high, next_nrz_high;
    logic [7:0] tmod, next_tmod;
    logic [15:0] taddr, next_taddr;

    // Stack ports
    logic asr_we;
    logic [`NMD_ASR_AW-1:0] asr_waddr;
    logic [15:0] asr_wdata;
    logic [15:0] asr_rdata;
    logic ist_we;
    logic [`NMD_STATUS_W-1:0] ist_rdata;

    assign dec = split_word(INSTR, ROW_POINTER_EN, ROW_POINTER);
    assign form = INSTR[`NMD_F_FORM];
    assign major = nmd_major_t'(INSTR[`NMD_F_MAJOR]);
    assign subop = nmd_subop_t'(INSTR[`NMD_F_SUBOP]);
    assign pc_inc = pc + 13'h0001;

    always_comb
    begin
        next_state = state;
        next_dec_q = dec_q;
        next_dec_valid = 1'b0;
        next_pc = pc;
        next_prog_addr = prog_addr;
        next_prog_read = 1'b0;
        next_sidx = sidx;
        next_iidx = iidx;
        next_int_en = int_en;
        next_restored = restored;
        next_restore_valid = 1'b0;
        next_prdata = prdata;
        next_prvalid = 1'b0;
        next_nrz_low = nrz_low;
        next_nrz_high = nrz_high;
        next_tmod = tmod;
        next_taddr = taddr;
        asr_we = 1'b0;
        asr_waddr = sidx;
        asr_wdata = {3'b000, pc_inc};
        ist_we = 1'b0;
        if (INT_ACCEPT)
        begin
            // Entry wins over an instruction in the same cycle
            asr_we = 1'b1;
            asr_wdata = {3'b000, pc};
            next_sidx = sidx + 3'h1;
            ist_we = 1'b1;
            next_iidx = iidx + 2'h1;
            next_pc = INT_VECTOR;
            next_int_en = 1'b0;
            next_state = NMD_ST_RUN;
        end
        else if (INSTR_VALID)
        begin
            next_pc = pc_inc;
            case (state)
                NMD_ST_SKIP:
                begin
                    next_state = NMD_ST_RUN;
                end
                NMD_ST_RUN:
                begin
                    next_dec_q = dec;
                    next_dec_valid = 1'b1;
                    if (!form && (major >= NMD_BR0))
                    begin
                        next_pc = {major[1:0], dec.branch_addr};
                    end
                    else if (form && (major == NMD_BR0))
                    begin
                        asr_we = 1'b1;
                        next_sidx = sidx + 3'h1;
                        next_pc = {pc[`NMD_F_PAGE], dec.branch_addr};
                    end
                    else if (!form && (major == NMD_MISC))
                    begin
                        case (subop)
                            NMD_S_INC_TA: next_taddr = taddr + 16'h0001;
                            NMD_S_MOVT:
                            begin
                                next_prog_addr = taddr;
                                next_prog_read = 1'b1;
                            end
                            NMD_S_BR_TA: next_pc = taddr[12:0];
                            NMD_S_CALL_TA:
                            begin
                                asr_we = 1'b1;
                                next_sidx = sidx + 3'h1;
                                next_pc = taddr[12:0];
                            end
                            NMD_S_RET, NMD_S_RETSK, NMD_S_RETI:
                            begin
                                next_sidx = sidx - 3'h1;
                                next_pc = asr_rdata[12:0];
                                if (subop == NMD_S_RETSK)
                                begin
                                    next_state = NMD_ST_SKIP;
                                end
                                if (subop == NMD_S_RETI)
                                begin
                                    next_iidx = iidx - 2'h1;
                                    next_restored = ist_rdata;
                                    next_restore_valid = 1'b1;
                                end
                            end
                            NMD_S_EI: next_int_en = 1'b1;
                            NMD_S_DI: next_int_en = 1'b0;
                            NMD_S_PUSH:
                            begin
                                asr_we = 1'b1;
                                asr_wdata = taddr;
                                next_sidx = sidx + 3'h1;
                            end
                            NMD_S_POP:
                            begin
                                next_sidx = sidx - 3'h1;
                                next_taddr = asr_rdata;
                            end
                            NMD_S_GET:
                            begin
                                next_prvalid = 1'b1;
                                case (dec.periph_addr)
                                    `NMD_PA_NRZ_LOW: next_prdata = {8'h00, nrz_low};
                                    `NMD_PA_NRZ_HIGH: next_prdata = {8'h00, nrz_high};
                                    `NMD_PA_TIMER_COUNT: next_prdata = {8'h00, TIMER_COUNT};
                                    `NMD_PA_TABLE_ADDRESS: next_prdata = taddr;
                                    default: next_prdata = `NMD_RST_WORD;
                                endcase
                            end
                            NMD_S_PUT:
                            begin
                                case (dec.periph_addr)
                                    `NMD_PA_NRZ_LOW: next_nrz_low = XFER_DATA[7:0];
                                    `NMD_PA_NRZ_HIGH: next_nrz_high = XFER_DATA[7:0];
                                    `NMD_PA_TIMER_MODULO: next_tmod = XFER_DATA[7:0];
                                    `NMD_PA_TABLE_ADDRESS: next_taddr = XFER_DATA;
                                    default: next_tmod = tmod;
                                endcase
                            end
                            default: next_pc = pc_inc;
                        endcase
                    end
                end
                default: next_state = NMD_ST_RUN;
            endcase
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            state <= NMD_ST_RUN;
            dec_q <= '0;
            dec_valid <= 1'b0;
            pc <= `NMD_RST_PC;
            prog_addr <= `NMD_RST_WORD;
            prog_read <= 1'b0;
            sidx <= '0;
            iidx <= '0;
            int_en <= 1'b0;
            restored <= '0;
            restore_valid <= 1'b0;
            prdata <= `NMD_RST_WORD;
            prvalid <= 1'b0;
            nrz_low <= `NMD_RST_BYTE;
            nrz_high <= `NMD_RST_BYTE;
            tmod <= `NMD_RST_BYTE;
            taddr <= `NMD_RST_WORD;
        end
        else
        begin
            state <= next_state;
            dec_q <= next_dec_q;
            dec_valid <= next_dec_valid;
            pc <= next_pc;
            prog_addr <= next_prog_addr;
            prog_read <= next_prog_read;
            sidx <= next_sidx;
            iidx <= next_iidx;
            int_en <= next_int_en;
            restored <= next_restored;
            restore_valid <= next_restore_valid;
            prdata <= next_prdata;
            prvalid <= next_prvalid;
            nrz_low <= next_nrz_low;
            nrz_high <= next_nrz_high;
            tmod <= next_tmod;
            taddr <= next_taddr;
        end
    end

    // Read address tracks the top entry after this cycle's update
    nmd_stack_mem #(.AW(`NMD_ASR_AW), .DW(16)) u_return_address_stack (
        .clk(CLOCK),
        .we(asr_we),
        .waddr(asr_waddr),
        .wdata(asr_wdata),
        .raddr(next_sidx - 3'h1),
        .rdata(asr_rdata)
    );

    nmd_stack_mem #(.AW(`NMD_IST_AW), .DW(`NMD_STATUS_W)) u_interrupt_save_stack (
        .clk(CLOCK),
        .we(ist_we),
        .waddr(iidx),
        .wdata(SAVED_STATUS),
        .raddr(next_iidx - 2'h1),
        .rdata(ist_rdata)
    );

    assign DECODE = dec_q;
    assign DECODE_VALID = dec_valid;
    assign PC = pc;
    assign PROG_ADDR = prog_addr;
    assign PROG_READ = prog_read;
    assign STACK_INDEX = sidx;
    assign INT_ENABLE = int_en;
    assign RESTORED_STATUS = restored;
    assign RESTORE_VALID = restore_valid;
    assign PERIPH_RDATA = prdata;
    assign PERIPH_RVALID = prvalid;
    assign NRZ_LOW = nrz_low;
    assign NRZ_HIGH = nrz_high;
    assign TIMER_MODULO = tmod;
    assign TABLE_ADDR = taddr;
    assign INT_LEVEL_FLAG = int_flag;

endmodule : nmd_decode

// ---- dv/nmd_decode_asserts.sv ----
// Purpose: Port-level checks for the opcode and operand decoder
// Assumes: Sees only the top module ports
// Notes: Bound into every nmd_decode instance
`timescale 1ns/1ps
`include "nmd_regs.svh"

module nmd_decode_chk
    import nmd_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // Inputs seen
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR,
    input wire logic [2:0] ROW_POINTER,
    input wire logic ROW_POINTER_EN,
    input wire logic [7:0] TIMER_COUNT,
    input wire logic INT_ACCEPT,
    input wire logic [12:0] INT_VECTOR,
    input wire logic INT_PIN,
    // Results
    input wire nmd_decode_t DECODE,
    input wire logic DECODE_VALID,
    input wire logic [12:0] PC,
    input wire logic INT_ENABLE,
    input wire logic [15:0] PERIPH_RDATA,
    input wire logic PERIPH_RVALID,
    input wire logic INT_LEVEL_FLAG
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    AST_TAKEN: assert property (DECODE_VALID |-> $past(INSTR_VALID) && !$past(INT_ACCEPT))
        else $error("decode without taken instruction");
    AST_OPCODE: assert property (DECODE_VALID |-> DECODE.opcode == $past(INSTR[15:11]))
        else $error("opcode field wrong");
    AST_BRANCH_ADDR: assert property (DECODE_VALID |-> DECODE.branch_addr == $past(INSTR[10:0]))
        else $error("branch address wrong");
    AST_PAGE: assert property (DECODE_VALID && DECODE.opcode[4:2] == 3'b011
        |-> PC == {DECODE.opcode[1:0], DECODE.branch_addr}) else $error("page or offset wrong");
    AST_IMM: assert property (DECODE_VALID |-> DECODE.immediate_nibble == $past(INSTR[7:4]))
        else $error("immediate wrong");
    AST_BIT_SEL: assert property (DECODE_VALID |-> DECODE.bit_sel == $past(INSTR[7:4]))
        else $error("bit position wrong");
    AST_MEM_ADDR: assert property (DECODE_VALID |-> DECODE.mem_addr[3:0] == $past(INSTR[3:0])
        && DECODE.mem_addr[6:4] == ($past(ROW_POINTER_EN) ? $past(ROW_POINTER) : $past(INSTR[10:8])))
        else $error("memory address wrong");
    AST_PERIPH: assert property (DECODE_VALID |-> DECODE.periph_addr == $past(INSTR[6:0]))
        else $error("peripheral address wrong");
    AST_REGFILE: assert property (DECODE_VALID |-> DECODE.regfile_addr == $past(INSTR[6:0]))
        else $error("register file address wrong");
    AST_INT_ENTRY: assert property (INT_ACCEPT |=> PC == $past(INT_VECTOR) && !INT_ENABLE)
        else $error("interrupt entry wrong");
    AST_COUNT_READ: assert property (PERIPH_RVALID && $past(INSTR[6:0]) == 7'h05
        |-> PERIPH_RDATA == {8'h00, $past(TIMER_COUNT)}) else $error("count read wrong");
    AST_PIN_HIGH: assert property (INT_PIN [*6] |-> INT_LEVEL_FLAG)
        else $error("flag not high");
    AST_PIN_LOW: assert property (!INT_PIN [*6] |-> !INT_LEVEL_FLAG)
        else $error("flag not low");
endmodule : nmd_decode_chk

bind nmd_decode nmd_decode_chk i_chk (.CLOCK(CLOCK), .RST(RST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
    .ROW_POINTER(ROW_POINTER), .ROW_POINTER_EN(ROW_POINTER_EN), .TIMER_COUNT(TIMER_COUNT),
    .INT_ACCEPT(INT_ACCEPT), .INT_VECTOR(INT_VECTOR), .INT_PIN(INT_PIN), .DECODE(DECODE),
    .DECODE_VALID(DECODE_VALID), .PC(PC), .INT_ENABLE(INT_ENABLE), .PERIPH_RDATA(PERIPH_RDATA),
    .PERIPH_RVALID(PERIPH_RVALID), .INT_LEVEL_FLAG(INT_LEVEL_FLAG));

// ---- dv/nmd_decode_tb.sv ----
// Purpose: Self-checking bench for the opcode and operand decoder
// Assumes: Inputs change on the falling edge
// Notes: Results are read one falling edge after each instruction
`timescale 1ns/1ps

module nmd_decode_tb import nmd_pkg::*;;
    logic clk, rst, iv, rp_en, int_acc, int_pin, dv, prd, ie, rsv, pv, flag;
    logic [15:0] instr, xd, pa, prdata, ta;
    logic [2:0] rp, si, sidx;
    logic [7:0] tc, ss, rst_st, nlo, nhi, tm;
    logic [12:0] vec, pc;
    nmd_decode_t dec;
    int bad_count, checked, k, n;

    nmd_decode i_dut (.CLOCK(clk), .RST(rst), .INSTR_VALID(iv), .INSTR(instr), .ROW_POINTER(rp),
        .ROW_POINTER_EN(rp_en), .XFER_DATA(xd), .TIMER_COUNT(tc), .INT_ACCEPT(int_acc), .INT_VECTOR(vec),
        .SAVED_STATUS(ss), .INT_PIN(int_pin), .DECODE(dec), .DECODE_VALID(dv), .PC(pc), .PROG_ADDR(pa),
        .PROG_READ(prd), .STACK_INDEX(sidx), .INT_ENABLE(ie), .RESTORED_STATUS(rst_st), .RESTORE_VALID(rsv),
        .PERIPH_RDATA(prdata), .PERIPH_RVALID(pv), .NRZ_LOW(nlo), .NRZ_HIGH(nhi), .TIMER_MODULO(tm),
        .TABLE_ADDR(ta), .INT_LEVEL_FLAG(flag));

    task automatic conclude();
        if (bad_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic issue(input logic [15:0] i);
        @(negedge clk);
        iv = 1'b1;
        instr = i;
        @(negedge clk);
        iv = 1'b0;
    endtask : issue

    function automatic logic [15:0] misc(input logic [3:0] s, input logic [6:0] p);
        return {5'b0_0111, s, p};
    endfunction : misc

    task automatic put(input logic [6:0] p, input logic [15:0] d);
        xd = d;
        issue(misc(4'hD, p));
    endtask : put

    task automatic get(input logic [6:0] p, input logic [15:0] exp);
        issue(misc(4'hC, p));
        chk("periph_rvalid", 16'h0001, pv);
        chk("periph_rdata", exp, prdata);
    endtask : get

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        #2_000_000;
        bad_count++;
        conclude();
    end

    initial
    begin
        {rst, int_pin} = 2'b11;
        {iv, rp_en, int_acc, instr, xd, rp, tc, ss, vec} = '0;
        repeat (20) @(negedge clk);
        chk("int_level_flag", 16'h0001, flag);
        rst = 1'b0;
        @(negedge clk);
        chk("pc", 16'h0000, pc);
        int_pin = 1'b0;
        n = 0;
        while (flag !== 1'b0 && n < 8)
        begin
            @(negedge clk);
            n++;
        end
        chk("int_level_flag", 16'h0000, flag);
        for (k = 0; k < 14; k++)
        begin
            issue({k[0], k[4:1], 11'h5A3});
            chk("decode_valid", 16'h0001, dv);
            chk("opcode", {k[0], k[4:1]}, dec.opcode);
            chk("immediate", 16'h000A, dec.immediate_nibble);
            chk("reg_col", 16'h000A, dec.reg_col);
            chk("mem_addr", 16'h0053, dec.mem_addr);
            chk("branch_addr", 16'h05A3, dec.branch_addr);
        end
        rp = 3'h6;
        rp_en = 1'b1;
        issue(16'h05A3);
        chk("mem_addr", 16'h0063, dec.mem_addr);
        rp_en = 1'b0;
        issue(16'hF2C7);
        chk("bit_sel", 16'h000C, dec.bit_sel);
        issue(misc(4'hE, 7'h3B));
        chk("regfile_addr", 16'h003B, dec.regfile_addr);
        put(7'h03, 16'h00AB);
        chk("nrz_low", 16'h00AB, nlo);
        get(7'h03, 16'h00AB);
        put(7'h04, 16'h00CD);
        chk("nrz_high", 16'h00CD, nhi);
        get(7'h04, 16'h00CD);
        put(7'h06, 16'h005E);
        chk("timer_modulo", 16'h005E, tm);
        get(7'h06, 16'h0000);
        tc = 8'h77;
        put(7'h05, 16'h0011);
        get(7'h05, 16'h0077);
        put(7'h40, 16'hBEEF);
        chk("table_addr", 16'hBEEF, ta);
        get(7'h40, 16'hBEEF);
        chk("periph_addr", 16'h0040, dec.periph_addr);
        get(7'h11, 16'h0000);
        issue(misc(4'h0, 7'h00));
        chk("table_addr", 16'hBEF0, ta);
        issue(misc(4'h2, 7'h00));
        chk("prog_read", 16'h0001, prd);
        chk("prog_addr", 16'hBEF0, pa);
        for (k = 0; k < 4; k++)
        begin
            issue({3'b011, k[1:0], 11'h123 + 11'(k)});
            chk("pc", {k[1:0], 11'h123 + 11'(k)}, pc);
        end
        si = sidx;
        issue(16'hE055);
        chk("pc", 16'h1855, pc);
        chk("stack_moved", 16'h0001, sidx !== si);
        issue(misc(4'h5, 7'h00));
        chk("pc", 16'h1927, pc);
        chk("stack_index", si, sidx);
        issue(misc(4'h7, 7'h00));
        chk("int_enable", 16'h0001, ie);
        ss = 8'h5C;
        vec = 13'h0ABC;
        @(negedge clk);
        {int_acc, iv, instr} = {2'b11, 16'h6000};
        @(negedge clk);
        {int_acc, iv} = 2'b00;
        chk("pc", 16'h0ABC, pc);
        chk("int_enable", 16'h0000, ie);
        chk("decode_valid", 16'h0000, dv);
        issue(misc(4'h9, 7'h00));
        chk("pc", 16'h1928, pc);
        chk("restore_valid", 16'h0001, rsv);
        chk("restored_status", 16'h005C, rst_st);
        issue(misc(4'h7, 7'h00));
        issue(misc(4'h8, 7'h00));
        chk("int_enable", 16'h0000, ie);
        put(7'h40, 16'h1234);
        issue(misc(4'hA, 7'h00));
        issue(misc(4'h0, 7'h00));
        issue(misc(4'h3, 7'h00));
        chk("pc", 16'h1235, pc);
        issue(misc(4'hB, 7'h00));
        chk("table_addr", 16'h1234, ta);
        chk("stack_index", si, sidx);
        issue(misc(4'h4, 7'h00));
        chk("pc", 16'h1234, pc);
        issue(misc(4'h6, 7'h00));
        chk("pc", 16'h1237, pc);
        issue(misc(4'h0, 7'h00));
        chk("decode_valid", 16'h0000, dv);
        chk("table_addr", 16'h1234, ta);
        chk("pc", 16'h1238, pc);
        conclude();
    end
endmodule : nmd_decode_tb
